// file: logic/loop_out_map.svh
// register offsets, field positions, reset values and timing counts of the channel status/enable bank
`ifndef LOOP_OUT_MAP_SVH
`define LOOP_OUT_MAP_SVH
`define OPEN_LOOP_IDX        4'hc
`define OPEN_LOOP_ADDR       8'h30
`define MSG_ENABLE_IDX       4'he
`define MSG_ENABLE_ADDR      8'h38
`define IRQ_STATUS_ADDR      8'h40
`define IRQ_MASK_ADDR        8'h44
`define VAR_SELECT_ADDR      8'h48
`define VAR_DATA_ADDR        8'h4c
`define MV_FIELD_LSB         0
`define HART_FIELD_LSB       8
`define NUM_CHANNELS         8
`define NUM_VARIABLES        4
`define MSG_ENABLE_RESET     16'h0000
`define POLL_PERIOD_US       1000
`define CLK_PERIOD_NS        4
`define POLL_PERIOD_CYC      ((`POLL_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`endif

// file: logic/loop_out_pkg.sv
// types shared by the channel status/enable bank
package loop_out_pkg;
   typedef enum logic [1:0] {
      POLL_IDLE  = 2'b00,
      POLL_ASK   = 2'b01,
      POLL_WAIT  = 2'b11
   } poll_state_t;
   typedef logic [31:0] ieee_float_t;
endpackage

// file: logic/open_loop_detect.sv
// per-channel readback deadband comparator
module open_loop_detect #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_i,      // system clock
   input  wire logic             srst_i,     // sync reset
   input  wire logic [WIDTH-1:0] command_i,  // commanded output
   input  wire logic [WIDTH-1:0] measure_i,  // synchronised readback
   input  wire logic [WIDTH-1:0] deadband_i, // allowed deviation
   input  wire logic             check_i,    // compare strobe
   output logic                  bad_o       // deviation beyond deadband
);
   // absolute difference, used for both directions
   function automatic logic [WIDTH-1:0] abs_diff(input logic [WIDTH-1:0] a, input logic [WIDTH-1:0] b);
      abs_diff = (a > b) ? a - b : b - a;
   endfunction

   // verdict held until the next compare
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bad_o <= 1'b0;
      end else if (check_i) begin
         bad_o <= (abs_diff(command_i, measure_i) > deadband_i);
      end
   end
endmodule // open_loop_detect

// file: logic/loop_out_regs.sv
// channel open-loop status and field messaging enable registers with multi-variable poller
// Notes on behaviour
// - each channel sets its bad bit when readback deviates beyond deadband.
// - pass/fail word at index 12 is read-only; upper byte unused.
// - enable word index 14 low byte enables multi-variable messaging per channel.
// - enabled channels periodically fetch the field device's extra variables.
// - up to four extra variables per field device are kept.
// - each retrieved variable is carried as an IEEE float word.
// - enable word high byte gates all field traffic per channel.
// - a set high-byte bit marks that channel as field-protocol capable.
`include "loop_out_map.svh"
module loop_out_regs #(
   parameter int NCH        = `NUM_CHANNELS,
   parameter int DWIDTH     = 16,
   parameter int POLL_CYC   = `POLL_PERIOD_CYC
) (
   input  wire logic                  clk_i,        // 250 MHz clock
   input  wire logic                  srst_i,       // sync reset, high
   input  wire logic [7:0]            addr_i,       // byte address
   input  wire logic [31:0]           wdata_i,      // write data
   input  wire logic                  wr_i,         // write strobe
   input  wire logic                  rd_i,         // read strobe
   output logic [31:0]                rdata_o,      // read data, next cycle
   input  wire logic [NCH*DWIDTH-1:0] command_i,    // commanded values
   input  wire logic [NCH*DWIDTH-1:0] measure_i,    // readback, from pins
   input  wire logic [DWIDTH-1:0]     deadband_i,   // deviation limit
   input  wire logic                  check_i,      // compare strobe
   output logic                       var_req_o,    // fetch request
   output logic [2:0]                 var_chan_o,   // channel of fetch
   input  wire logic                  var_ack_i,    // fetch answer valid
   input  wire logic [127:0]          var_data_i,   // four floats
   output logic [NCH-1:0]             hart_en_o,    // per-channel traffic gate
   output logic [NCH-1:0]             mv_en_o,      // effective mv enable
   output logic                       irq_o         // level interrupt
);
   logic [NCH*DWIDTH-1:0] meas_s1;
   logic [NCH*DWIDTH-1:0] meas_s2;
   logic [NCH-1:0]        bad;
   logic [NCH-1:0]        bad_q;
   logic [NCH-1:0]        mv_en;
   logic [NCH-1:0]        hart_en;
   logic [NCH-1:0]        irq_status;
   logic [NCH-1:0]        irq_mask;
   logic [4:0]            var_sel;
   loop_out_pkg::ieee_float_t var_mem [NCH*`NUM_VARIABLES];
   loop_out_pkg::poll_state_t state;
   logic [31:0]           poll_cnt;
   logic [2:0]            poll_ch;
   logic                  wr_enable;
   logic                  wr_status;

   // readback comes from pins: two stages before comparison
   always_ff @(posedge clk_i) begin
      meas_s1 <= measure_i;
      meas_s2 <= meas_s1;
   end

   // one comparator per channel
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      open_loop_detect #(.WIDTH(DWIDTH)) u_det (
         .clk_i      (clk_i),
         .srst_i     (srst_i),
         .command_i  (command_i[g*DWIDTH +: DWIDTH]),
         .measure_i  (meas_s2[g*DWIDTH +: DWIDTH]),
         .deadband_i (deadband_i),
         .check_i    (check_i),
         .bad_o      (bad[g])
      );
   end

   assign wr_enable = wr_i && (addr_i == `MSG_ENABLE_ADDR);
   assign wr_status = wr_i && (addr_i == `IRQ_STATUS_ADDR);

   // enable word; only the 16 defined bits are stored
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mv_en   <= NCH'(`MSG_ENABLE_RESET);
         hart_en <= NCH'(`MSG_ENABLE_RESET);
      end else if (wr_enable) begin
         mv_en   <= wdata_i[`MV_FIELD_LSB +: NCH];
         hart_en <= wdata_i[`HART_FIELD_LSB +: NCH];
      end
   end

   // mask and variable selector
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_mask <= '0;
         var_sel  <= '0;
      end else if (wr_i) begin
         if (addr_i == `IRQ_MASK_ADDR) begin
            irq_mask <= wdata_i[NCH-1:0];
         end
         if (addr_i == `VAR_SELECT_ADDR) begin
            var_sel <= wdata_i[4:0];
         end
      end
   end

   // new bad channels raise sticky status; set beats write-one-clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bad_q      <= '0;
         irq_status <= '0;
      end else begin
         bad_q      <= bad;
         irq_status <= (irq_status & ~(wr_status ? wdata_i[NCH-1:0] : '0)) | (bad & ~bad_q);
      end
   end

   // gated enables; mv only flows with field traffic allowed
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hart_en_o <= '0;
         mv_en_o   <= '0;
         irq_o     <= 1'b0;
      end else begin
         hart_en_o <= hart_en;
         mv_en_o   <= mv_en & hart_en;
         irq_o     <= |(irq_status & irq_mask);
      end
   end

   // periodic poller walks the channels, skipping disabled ones
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state      <= loop_out_pkg::POLL_IDLE;
         poll_cnt   <= '0;
         poll_ch    <= '0;
         var_req_o  <= 1'b0;
         var_chan_o <= '0;
      end else begin
         case (state)
            loop_out_pkg::POLL_IDLE: begin
               var_req_o <= 1'b0;
               if (poll_cnt >= 32'(POLL_CYC - 1)) begin
                  poll_cnt <= '0;
                  if (mv_en[poll_ch] && hart_en[poll_ch]) begin
                     state <= loop_out_pkg::POLL_ASK;
                  end else begin
                     poll_ch <= poll_ch + 3'h1;
                  end
               end else begin
                  poll_cnt <= poll_cnt + 32'h1;
               end
            end
            // gate checked again: a write may drop it between the due tick and the ask
            loop_out_pkg::POLL_ASK: begin
               if (hart_en[poll_ch]) begin
                  var_req_o  <= 1'b1;
                  var_chan_o <= poll_ch;
                  state      <= loop_out_pkg::POLL_WAIT;
               end else begin
                  poll_ch <= poll_ch + 3'h1;
                  state   <= loop_out_pkg::POLL_IDLE;
               end
            end
            loop_out_pkg::POLL_WAIT: begin
               var_req_o <= 1'b0;
               if (var_ack_i || !hart_en[poll_ch]) begin  // abort if gate dropped
                  poll_ch <= poll_ch + 3'h1;
                  state   <= loop_out_pkg::POLL_IDLE;
               end
            end
            default: begin
               state <= loop_out_pkg::POLL_IDLE;
            end
         endcase
      end
   end

   // store four floats per channel; reads leave them, the channel's next fetch overwrites them
   always_ff @(posedge clk_i) begin
      if (state == loop_out_pkg::POLL_WAIT && var_ack_i && hart_en[poll_ch]) begin
         for (int v = 0; v < `NUM_VARIABLES; v++) begin
            var_mem[{poll_ch, 2'(v)}] <= var_data_i[v*32 +: 32];
         end
      end
   end

   // read mux; writes to status word have no effect, unused bits zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            `OPEN_LOOP_ADDR:  rdata_o <= 32'(bad);
            `MSG_ENABLE_ADDR: rdata_o <= 32'({hart_en, mv_en});
            `IRQ_STATUS_ADDR: rdata_o <= 32'(irq_status);
            `IRQ_MASK_ADDR:   rdata_o <= 32'(irq_mask);
            `VAR_SELECT_ADDR: rdata_o <= 32'(var_sel);
            `VAR_DATA_ADDR:   rdata_o <= var_mem[var_sel];
            default:          rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   sequence s_write_enable;
      wr_i && addr_i == `MSG_ENABLE_ADDR;
   endsequence

   a_enable_stored: assert property (@(posedge clk_i) disable iff (srst_i)
      s_write_enable |=> hart_en == $past(wdata_i[15:8]) && mv_en == $past(wdata_i[7:0]))
      else $error("enable word not stored");
   a_gate_follows: assert property (@(posedge clk_i) disable iff (srst_i)
      s_write_enable ##1 !wr_i |=> hart_en_o == hart_en && (mv_en_o & ~hart_en) == '0)
      else $error("traffic gate mismatch");
   a_open_loop_read: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == `OPEN_LOOP_ADDR |=> rdata_o == 32'($past(bad)))
      else $error("status read wrong");
   a_unused_zero: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == `MSG_ENABLE_ADDR |=> rdata_o[31:16] == 16'h0000)
      else $error("unused bits not zero");
   a_status_ro: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == `OPEN_LOOP_ADDR |=> $stable(hart_en) && $stable(mv_en))
      else $error("status write had effect");
   a_no_req_gated: assert property (@(posedge clk_i) disable iff (srst_i)
      var_req_o |-> $past(hart_en[poll_ch]))
      else $error("request on gated channel");
   a_ask_enabled: assert property (@(posedge clk_i) disable iff (srst_i)
      state == loop_out_pkg::POLL_ASK && hart_en[poll_ch] |-> ##1 var_req_o ##1 !var_req_o)
      else $error("request pulse malformed");
   a_bad_detect: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(bad[0]) |=> irq_status[0])
      else $error("bad edge not latched");

   // poller steps, shared by the properties below
   sequence s_poll_due;
      state == loop_out_pkg::POLL_IDLE && poll_cnt >= 32'(POLL_CYC - 1);
   endsequence

   sequence s_fetch_done;
      state == loop_out_pkg::POLL_WAIT && var_ack_i && hart_en[poll_ch];
   endsequence

   // register bus side
   a_mask_stored: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == `IRQ_MASK_ADDR |=> irq_mask == $past(wdata_i[NCH-1:0]))
      else $error("mask not stored");

   a_select_stored: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == `VAR_SELECT_ADDR |=> var_sel == $past(wdata_i[4:0]))
      else $error("selector not stored");

   a_rdata_idle: assert property (@(posedge clk_i) disable iff (srst_i)
      !rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data outside read slot");

   a_rdata_unmapped: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && !(addr_i inside {`OPEN_LOOP_ADDR, `MSG_ENABLE_ADDR, `IRQ_STATUS_ADDR,
                               `IRQ_MASK_ADDR, `VAR_SELECT_ADDR, `VAR_DATA_ADDR})
      |=> rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_enable_read: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == `MSG_ENABLE_ADDR |=> rdata_o[15:0] == $past({hart_en, mv_en}))
      else $error("enable word read wrong");

   a_status_upper: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == `OPEN_LOOP_ADDR |=> rdata_o[31:8] == 24'h00_0000)
      else $error("status upper bits set");

   a_var_read: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == `VAR_DATA_ADDR |=> rdata_o == $past(var_mem[var_sel]))
      else $error("variable read wrong");

   // interrupt side
   a_set_wins: assert property (@(posedge clk_i) disable iff (srst_i)
      (bad & ~bad_q) != '0 |=> (irq_status & $past(bad & ~bad_q)) == $past(bad & ~bad_q))
      else $error("new bad edge lost");

   a_w1c_clears: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_status && (bad & ~bad_q) == '0 |=> (irq_status & $past(wdata_i[NCH-1:0])) == '0)
      else $error("write one did not clear");

   a_status_holds: assert property (@(posedge clk_i) disable iff (srst_i)
      !wr_status && (bad & ~bad_q) == '0 |=> $stable(irq_status))
      else $error("status changed with no event");

   a_irq_level: assert property (@(posedge clk_i) disable iff (srst_i)
      1'b1 |=> irq_o == $past(|(irq_status & irq_mask)))
      else $error("interrupt level wrong");

   // traffic gates
   a_hart_out: assert property (@(posedge clk_i) disable iff (srst_i)
      1'b1 |=> hart_en_o == $past(hart_en))
      else $error("field enable output wrong");

   a_mv_out: assert property (@(posedge clk_i) disable iff (srst_i)
      1'b1 |=> mv_en_o == $past(mv_en & hart_en))
      else $error("mv enable output ungated");

   // poller
   a_poll_count: assert property (@(posedge clk_i) disable iff (srst_i)
      state == loop_out_pkg::POLL_IDLE && poll_cnt < 32'(POLL_CYC - 1) |=> poll_cnt == $past(poll_cnt) + 32'h1)
      else $error("poll counter stuck");

   a_poll_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
      s_poll_due |=> poll_cnt == 32'h0)
      else $error("poll counter not wrapped");

   a_skip_disabled: assert property (@(posedge clk_i) disable iff (srst_i)
      s_poll_due ##0 !(mv_en[poll_ch] && hart_en[poll_ch])
      |=> state == loop_out_pkg::POLL_IDLE && poll_ch == $past(poll_ch) + 3'h1)
      else $error("disabled channel not skipped");

   a_due_asks: assert property (@(posedge clk_i) disable iff (srst_i)
      s_poll_due ##0 (mv_en[poll_ch] && hart_en[poll_ch]) |=> state == loop_out_pkg::POLL_ASK)
      else $error("enabled channel not asked");

   a_ask_req: assert property (@(posedge clk_i) disable iff (srst_i)
      state == loop_out_pkg::POLL_ASK && hart_en[poll_ch]
      |=> var_req_o && var_chan_o == $past(poll_ch) && state == loop_out_pkg::POLL_WAIT)
      else $error("ask did not request");

   a_ask_gate: assert property (@(posedge clk_i) disable iff (srst_i)
      state == loop_out_pkg::POLL_ASK && !hart_en[poll_ch] |=> !var_req_o && state == loop_out_pkg::POLL_IDLE)
      else $error("ask on gated channel");

   a_req_only_ask: assert property (@(posedge clk_i) disable iff (srst_i)
      state != loop_out_pkg::POLL_ASK |=> !var_req_o)
      else $error("request outside ask");

   a_req_chan: assert property (@(posedge clk_i) disable iff (srst_i)
      var_req_o |-> var_chan_o == poll_ch)
      else $error("request channel drifted");

   a_wait_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      state == loop_out_pkg::POLL_WAIT && !var_ack_i && hart_en[poll_ch]
      |=> state == loop_out_pkg::POLL_WAIT && $stable(poll_ch))
      else $error("wait left early");

   a_wait_exit: assert property (@(posedge clk_i) disable iff (srst_i)
      state == loop_out_pkg::POLL_WAIT && (var_ack_i || !hart_en[poll_ch]) |=> state == loop_out_pkg::POLL_IDLE)
      else $error("wait not left");

   a_store_var: assert property (@(posedge clk_i) disable iff (srst_i)
      s_fetch_done |=> var_mem[{$past(poll_ch), 2'b00}] == $past(var_data_i[31:0]))
      else $error("first variable not stored");

   a_store_last: assert property (@(posedge clk_i) disable iff (srst_i)
      s_fetch_done |=> var_mem[{$past(poll_ch), 2'b11}] == $past(var_data_i[127:96]))
      else $error("fourth variable not stored");
endmodule // loop_out_regs

// file: test/field_device_model.sv
// behavioural field device that answers variable fetches
module field_device_model (
   input  wire logic          clk_i,   // system clock
   input  wire logic          srst_i,  // sync reset, high
   input  wire logic          req_i,   // fetch request pulse
   input  wire logic [2:0]    chan_i,  // channel asked
   output logic               ack_o,   // answer valid pulse
   output logic [127:0]       data_o   // four floats
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0]   wait_cnt;
   logic [2:0]   chan;
   logic [127:0] frame;
   // delay grows with channel, so prompt and slow answers both occur
   always_ff @(posedge clk_i) begin
      ack_o <= 1'b0;
      if (srst_i) begin
         wait_cnt <= 5'h00;
         frame    <= '0;
      end else if (req_i) begin
         wait_cnt <= 5'h01 + 5'(chan_i) * 5'h03;
         chan     <= chan_i;
      end else if (wait_cnt == 5'h01) begin
         wait_cnt <= 5'h00;
         ack_o    <= 1'b1;
         for (int k = 0; k < 4; k++) begin
            frame[32*k+:32] <= 32'h4000_0000 | {chan, 2'(k)};
         end
      end else if (wait_cnt != 5'h00) begin
         wait_cnt <= wait_cnt - 5'h01;
      end
   end
   // released data lines show the inverse, never a stale copy
   assign data_o = ack_o ? frame : ~frame;
endmodule // field_device_model

// file: test/testbench.sv
// self-checking bench of the channel status and enable bank
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_i, srst_i, wr_i, rd_i, check_i, var_req_o, var_ack_i, irq_o;
   logic [7:0]   addr_i, hart_en_o, mv_en_o, bad;
   logic [31:0]  wdata_i, rdata_o, rval, rb, seed;
   logic [127:0] command_i, measure_i, var_data_i;
   logic [15:0]  deadband_i, en, cmd;
   logic [2:0]   var_chan_o;
   int           mismatches, n_tests, d, nreq;
   bit           watch;
   loop_out_regs #(.POLL_CYC(8)) i_loop_out_regs (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .command_i, .measure_i, .deadband_i, .check_i, .var_req_o, .var_chan_o, .var_ack_i, .var_data_i,
      .hart_en_o, .mv_en_o, .irq_o);
   field_device_model i_field_device_model (.clk_i, .srst_i, .req_i(var_req_o), .chan_i(var_chan_o),
      .ack_o(var_ack_i), .data_o(var_data_i));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] var_word(input logic [2:0] c, input logic [1:0] k);
      return 32'h4000_0000 | {c, k};
   endfunction
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   // read data stand one cycle only, so the next cycle must show zero
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
      settle(1);
      `CHK(rdata_o, 32'h0)
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // any fetch while watched must belong to a fully enabled channel
   always @(posedge clk_i) begin
      if (watch && var_req_o === 1'b1) begin
         nreq++;
         `CHK(en[var_chan_o] & en[var_chan_o + 8], 1'b1)
      end
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      {wr_i, rd_i, check_i, addr_i, wdata_i, command_i, measure_i, deadband_i} = '0;
      seed   = 32'd85;
      srst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(8'h38, rb); `CHK(rb, 32'h0)
      `CHK({hart_en_o, mv_en_o}, 16'h0)
      wr(8'h30, 32'hffff); rd(8'h30, rb); `CHK(rb, 32'h0)
      wr(8'h3c, 32'hffff); rd(8'h3c, rb); `CHK(rb, 32'h0)
      $display("test reset_access done");
      for (int i = 0; i < 8; i++) begin
         rval = rnd();
         wr(8'h38, rval); rd(8'h38, rb); `CHK(rb, {16'h0, rval[15:0]})
         `CHK(hart_en_o, rval[15:8])
         `CHK(mv_en_o, rval[15:8] & rval[7:0])
      end
      $display("test enable_word done");
      // deviations of exactly the deadband and one beyond it
      deadband_i <= 16'h0100;
      for (int c = 0; c < 8; c++) begin
         d = (c == 0) ? 256 : (c == 1) ? -257 : int'(rnd() % 600) - 300;
         cmd = 16'h4000 + 16'(rnd() & 32'h7fff);
         command_i[16*c+:16] <= cmd;
         measure_i[16*c+:16] <= cmd + 16'(d);
         bad[c] = (d > 256) || (d < -256);
      end
      settle(4); check_i <= 1'b1; settle(1); check_i <= 1'b0; settle(2);
      rd(8'h30, rb); `CHK(rb, {24'h0, bad})
      rd(8'h40, rb); `CHK(rb, {24'h0, bad})
      `CHK(irq_o, 1'b0)
      wr(8'h44, 32'hff); settle(3); `CHK(irq_o, 1'b1)
      wr(8'h40, {24'h0, bad}); settle(3); `CHK(irq_o, 1'b0)
      rd(8'h40, rb); `CHK(rb, 32'h0)
      $display("test open_loop_irq done");
      // channel 2 fully on, channel 5 multi-variable only
      rval = rnd() | 32'h0404;
      rval[13] = 1'b0;
      rval[5] = 1'b1;
      en = rval[15:0];
      wr(8'h38, rval); settle(4);
      watch = 1'b1;
      settle(400);
      watch = 1'b0;
      `CHK(nreq > 0, 1'b1)
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 4; k++) begin
            if (en[c] & en[c + 8]) begin
               wr(8'h48, 32'(c * 4 + k)); rd(8'h4c, rb); `CHK(rb, var_word(3'(c), 2'(k)))
            end
         end
      end
      $display("test poller done");
      complete_run();
   end
endmodule // testbench
